// file: pmpu_regs.svh
// constants shared by both ends of the parallel pixel write port
// assumes nothing but inclusion from the package
`ifndef PMPU_REGS_SVH
`define PMPU_REGS_SVH

`define PMPU_LINE_W 18
`define PMPU_WORD_W 16
`define PMPU_STRAP_W 4
`define PMPU_CMD_W 8
`define PMPU_IM_NINE_II 4'hB
`define PMPU_IM_WIDE_I 4'h1
`define PMPU_IM_WIDE_II 4'h8
`define PMPU_FMT_565 3'h5
`define PMPU_FMT_666 3'h6
`define PMPU_MDT_00 2'h0
`define PMPU_MDT_01 2'h1
`define PMPU_MDT_10 2'h2
`define PMPU_MDT_11 2'h3
`define PMPU_FIFO_DEPTH 4
`define PMPU_ITEM_W 20
`define PMPU_HI_SLOT 15:10
`define PMPU_LO_SLOT 7:2
`define PMPU_NINE_SLOT 7:2

`endif

// file: pmpu_pkg.sv
// types and line mapping shared by the host end and the device end
// assumes pmpu_regs.svh is on the include path
package pmpu_pkg;
`include "pmpu_regs.svh"

    typedef enum logic [3:0] {
        BUS_NONE = 4'b0001,
        BUS_NINE = 4'b0010,
        BUS_WIDE_I = 4'b0100,
        BUS_WIDE_II = 4'b1000
    } pmpu_bus_e;

    typedef enum logic [2:0] {
        PH_FIRST = 3'b001,
        PH_SECOND = 3'b010,
        PH_THIRD = 3'b100
    } pmpu_phase_e;

    typedef logic [`PMPU_LINE_W-1:0] pmpu_lines_t;
    typedef logic [`PMPU_WORD_W-1:0] pmpu_word_t;

    typedef struct packed {
        pmpu_phase_e phase;
        logic [5:0] red;
        logic [5:0] green;
        logic [5:0] blue;
        logic [`PMPU_STRAP_W-1:0] strap;
        logic strapTaken;
        logic pushValid;
        logic [`PMPU_ITEM_W-1:0] pushData;
        logic busyWait;
        logic outValid;
        logic [`PMPU_ITEM_W-1:0] outData;
    } pmpu_dev_s;

    typedef struct packed {
        logic [2:0][`PMPU_WORD_W-1:0] words;
        logic [1:0] nWords;
        logic [1:0] idx;
        logic isCmd;
        logic gap;
        logic pairPhase;
        logic [5:0] heldBlue;
        logic [`PMPU_STRAP_W-1:0] strap;
        pmpu_lines_t lines;
        logic dcSelect;
        logic strobeN;
        logic cmdReady;
        logic pixReady;
    } pmpu_host_s;

    function automatic pmpu_bus_e pmpu_bus_kind(input logic [`PMPU_STRAP_W-1:0] strap);
        unique case (strap)
            `PMPU_IM_NINE_II: pmpu_bus_kind = BUS_NINE;
            `PMPU_IM_WIDE_I: pmpu_bus_kind = BUS_WIDE_I;
            `PMPU_IM_WIDE_II: pmpu_bus_kind = BUS_WIDE_II;
            default: pmpu_bus_kind = BUS_NONE;
        endcase
    endfunction : pmpu_bus_kind

    // nine-bit bus: logical word bits 8:0 sit on lines 17:9
    function automatic pmpu_word_t pmpu_lines_to_word(input pmpu_lines_t l, input pmpu_bus_e k);
        unique case (k)
            BUS_NINE: pmpu_lines_to_word = {7'h00, l[17:9]};
            BUS_WIDE_I: pmpu_lines_to_word = l[15:0];
            BUS_WIDE_II: pmpu_lines_to_word = {l[17:10], l[8:1]};
            default: pmpu_lines_to_word = 16'h0000;
        endcase
    endfunction : pmpu_lines_to_word

    function automatic pmpu_lines_t pmpu_word_to_lines(input pmpu_word_t w, input pmpu_bus_e k);
        unique case (k)
            BUS_NINE: pmpu_word_to_lines = {w[8:0], 9'h000};
            BUS_WIDE_I: pmpu_word_to_lines = {2'h0, w};
            BUS_WIDE_II: pmpu_word_to_lines = {w[15:8], 1'b0, w[7:0], 1'b0};
            default: pmpu_word_to_lines = 18'h00000;
        endcase
    endfunction : pmpu_word_to_lines
endpackage : pmpu_pkg

// file: pmpu_if.sv
// parallel write bus between the host end and the device end
// assumes both ends run on the same core_clk
interface pmpu_if;
    logic [17:0] parallelDataLines;
    logic dataCommandSelect;
    logic writeStrobeN;
    logic busyWait;
    logic [3:0] interfaceModePins;

    modport device (
        input parallelDataLines,
        input dataCommandSelect,
        input writeStrobeN,
        input interfaceModePins,
        output busyWait
    );

    modport host (
        output parallelDataLines,
        output dataCommandSelect,
        output writeStrobeN,
        output interfaceModePins,
        input busyWait
    );
endinterface : pmpu_if

// file: pmpu_device.sv
// device end: unpacks bus writes into commands and pixels, queued in a fifo
// assumes the host strobes at most every other cycle and obeys busyWait
// Functional notes
// - host straps mode pins 1011 for nine-bit
// - nine-bit 565: two writes per pixel
// - nine-bit 666 mode 00: two writes
// - nine-bit 666 mode 01: three writes
// - strap 0001: wide type I, commands low
// - strap 1000: wide type II, skips two lines
// - wide type I 565: one write
// - wide type II 565: one write
// - type I 666 mode 00: two pixels, three writes
// - type II 666 mode 00: same order
// - 666 mode 01: red/green then blue
// - 666 mode 10: blue split low bits
// - 666 mode 11: red top bits first

module pmpu_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4,
    parameter int CW = $clog2(DEPTH + 1),
    parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clkEnable,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [CW-1:0] fillCount
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [CW-1:0] count;
    } pmpu_fifo_s;

    pmpu_fifo_s fifo_reg;
    pmpu_fifo_s fifo_next;
    logic doPush;
    logic doPop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : bump

    assign inReady = (fifo_reg.count != CW'(DEPTH));
    assign outValid = (fifo_reg.count != '0);
    assign outData = fifo_reg.mem[fifo_reg.rdPtr];
    assign fillCount = fifo_reg.count;
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    always_comb begin
        fifo_next = fifo_reg;
        if (doPush) begin
            fifo_next.mem[fifo_reg.wrPtr] = inData;
            fifo_next.wrPtr = bump(fifo_reg.wrPtr);
        end
        if (doPop) begin
            fifo_next.rdPtr = bump(fifo_reg.rdPtr);
        end
        fifo_next.count = CW'(fifo_reg.count + CW'(doPush) - CW'(doPop));
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fifo_reg <= '0;
        end else if (clkEnable) begin
            fifo_reg <= fifo_next;
        end
    end
endmodule : pmpu_fifo

module pmpu_device #(
    parameter int FIFO_DEPTH = `PMPU_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clkEnable,
    pmpu_if.device bus,
    input wire logic [2:0] hostPixelFormat,
    input wire logic [1:0] wideTransferMode,
    input wire logic itemReady,
    output logic itemValid,
    output logic itemIsCommand,
    output logic itemIsWide,
    output pmpu_pkg::pmpu_lines_t itemData,
    output logic busKnown
);
    import pmpu_pkg::*;

    localparam int CW = $clog2(FIFO_DEPTH + 1);

    pmpu_dev_s st_reg;
    pmpu_dev_s st_next;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [`PMPU_ITEM_W-1:0] fifoOutData;
    logic [CW-1:0] fifoCount;
    pmpu_bus_e busKind;
    pmpu_word_t w;
    logic wr;

    // item = {isCommand, isWide, 18-bit payload}
    function automatic logic [`PMPU_ITEM_W-1:0] pix666(input logic [5:0] r, input logic [5:0] g,
                                                      input logic [5:0] b);
        pix666 = {1'b0, 1'b1, r, g, b};
    endfunction : pix666

    // 565 components are left aligned in their 6-bit fields
    function automatic logic [`PMPU_ITEM_W-1:0] pix565(input logic [4:0] r, input logic [5:0] g,
                                                      input logic [4:0] b);
        pix565 = {1'b0, 1'b0, r, 1'b0, g, b, 1'b0};
    endfunction : pix565

    assign busKind = pmpu_bus_kind(st_reg.strap);
    assign w = pmpu_lines_to_word(bus.parallelDataLines, busKind);
    assign wr = !bus.writeStrobeN && st_reg.strapTaken && (busKind != BUS_NONE);
    assign fifoOutReady = !st_reg.outValid || itemReady;

    pmpu_fifo #(
        .WIDTH(`PMPU_ITEM_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .clkEnable(clkEnable),
        .inValid(st_reg.pushValid),
        .inReady(fifoInReady),
        .inData(st_reg.pushData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData),
        .fillCount(fifoCount)
    );

    always_comb begin
        st_next = st_reg;
        st_next.pushValid = 1'b0;
        // straps are caught once, on the first enabled edge after reset release
        if (!st_reg.strapTaken) begin
            st_next.strap = bus.interfaceModePins;
            st_next.strapTaken = 1'b1;
        end
        if (wr && !bus.dataCommandSelect) begin
            st_next.pushData = {1'b1, 1'b0, 10'h000,
                                (busKind == BUS_NINE) ? w[8:1] : w[`PMPU_CMD_W-1:0]};
            st_next.pushValid = 1'b1;
            st_next.phase = PH_FIRST;
        end else if (wr && busKind == BUS_NINE && hostPixelFormat == `PMPU_FMT_565) begin
            if (st_reg.phase == PH_FIRST) begin
                st_next.red = {w[7:3], 1'b0};
                st_next.green = {w[2:0], 3'h0};
                st_next.phase = PH_SECOND;
            end else begin
                st_next.pushData = pix565(st_reg.red[5:1], {st_reg.green[5:3], w[7:5]}, w[4:0]);
                st_next.pushValid = 1'b1;
                st_next.phase = PH_FIRST;
            end
        end else if (wr && busKind == BUS_NINE && hostPixelFormat == `PMPU_FMT_666) begin
            if (wideTransferMode == `PMPU_MDT_01) begin
                unique case (st_reg.phase)
                    PH_FIRST: begin
                        st_next.red = w[`PMPU_NINE_SLOT];
                        st_next.phase = PH_SECOND;
                    end
                    PH_SECOND: begin
                        st_next.green = w[`PMPU_NINE_SLOT];
                        st_next.phase = PH_THIRD;
                    end
                    PH_THIRD: begin
                        st_next.pushData = pix666(st_reg.red, st_reg.green, w[`PMPU_NINE_SLOT]);
                        st_next.pushValid = 1'b1;
                        st_next.phase = PH_FIRST;
                    end
                endcase
            end else if (st_reg.phase == PH_FIRST) begin
                st_next.red = w[8:3];
                st_next.green = {w[2:0], 3'h0};
                st_next.phase = PH_SECOND;
            end else begin
                st_next.pushData = pix666(st_reg.red, {st_reg.green[5:3], w[8:6]}, w[5:0]);
                st_next.pushValid = 1'b1;
                st_next.phase = PH_FIRST;
            end
        end else if (wr && hostPixelFormat == `PMPU_FMT_565) begin
            st_next.pushData = pix565(w[15:11], w[10:5], w[4:0]);
            st_next.pushValid = 1'b1;
            st_next.phase = PH_FIRST;
        end else if (wr && hostPixelFormat == `PMPU_FMT_666) begin
            unique case (wideTransferMode)
                `PMPU_MDT_00: begin
                    unique case (st_reg.phase)
                        PH_FIRST: begin
                            st_next.red = w[`PMPU_HI_SLOT];
                            st_next.green = w[`PMPU_LO_SLOT];
                            st_next.phase = PH_SECOND;
                        end
                        PH_SECOND: begin
                            st_next.pushData = pix666(st_reg.red, st_reg.green, w[`PMPU_HI_SLOT]);
                            st_next.pushValid = 1'b1;
                            st_next.red = w[`PMPU_LO_SLOT];
                            st_next.phase = PH_THIRD;
                        end
                        PH_THIRD: begin
                            st_next.pushData = pix666(st_reg.red, w[`PMPU_HI_SLOT], w[`PMPU_LO_SLOT]);
                            st_next.pushValid = 1'b1;
                            st_next.phase = PH_FIRST;
                        end
                    endcase
                end
                `PMPU_MDT_01: begin
                    if (st_reg.phase == PH_FIRST) begin
                        st_next.red = w[`PMPU_HI_SLOT];
                        st_next.green = w[`PMPU_LO_SLOT];
                        st_next.phase = PH_SECOND;
                    end else begin
                        st_next.pushData = pix666(st_reg.red, st_reg.green, w[`PMPU_HI_SLOT]);
                        st_next.pushValid = 1'b1;
                        st_next.phase = PH_FIRST;
                    end
                end
                `PMPU_MDT_10: begin
                    if (st_reg.phase == PH_FIRST) begin
                        st_next.red = w[15:10];
                        st_next.green = w[9:4];
                        st_next.blue = {w[3:0], 2'h0};
                        st_next.phase = PH_SECOND;
                    end else begin
                        st_next.pushData = pix666(st_reg.red, st_reg.green,
                                                  {st_reg.blue[5:2], w[15:14]});
                        st_next.pushValid = 1'b1;
                        st_next.phase = PH_FIRST;
                    end
                end
                `PMPU_MDT_11: begin
                    if (st_reg.phase == PH_FIRST) begin
                        st_next.red = {w[1:0], 4'h0};
                        st_next.phase = PH_SECOND;
                    end else begin
                        st_next.pushData = pix666({st_reg.red[5:4], w[15:12]}, w[11:6], w[5:0]);
                        st_next.pushValid = 1'b1;
                        st_next.phase = PH_FIRST;
                    end
                end
            endcase
        end
        // one slot of slack covers the write already in flight when wait rises
        st_next.busyWait = (CW'(fifoCount + CW'(st_reg.pushValid) + CW'(st_next.pushValid))
                            >= CW'(FIFO_DEPTH - 1));
        if (fifoOutValid && fifoOutReady) begin
            st_next.outValid = 1'b1;
            st_next.outData = fifoOutData;
        end else if (itemReady) begin
            st_next.outValid = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '{phase: PH_FIRST, default: '0};
        end else if (clkEnable) begin
            st_reg <= st_next;
        end
    end

    assign bus.busyWait = st_reg.busyWait;
    assign itemValid = st_reg.outValid;
    assign itemIsCommand = st_reg.outData[`PMPU_ITEM_W-1];
    assign itemIsWide = st_reg.outData[`PMPU_ITEM_W-2];
    assign itemData = st_reg.outData[`PMPU_LINE_W-1:0];
    assign busKnown = st_reg.strapTaken && (busKind != BUS_NONE);
endmodule : pmpu_device

// file: pmpu_host.sv
// host end: packs commands and pixels into strobed bus writes
// assumes strapSelect is held steady from reset onward
module pmpu_host (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clkEnable,
    pmpu_if.host bus,
    input wire logic [3:0] strapSelect,
    input wire logic [2:0] hostPixelFormat,
    input wire logic [1:0] wideTransferMode,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    output logic cmdReady,
    input wire logic pixValid,
    input wire pmpu_pkg::pmpu_lines_t pixRgb,
    output logic pixReady
);
    import pmpu_pkg::*;

    pmpu_host_s st_reg;
    pmpu_host_s st_next;
    pmpu_bus_e busKind;
    logic [5:0] r;
    logic [5:0] g;
    logic [5:0] b;
    logic takeCmd;
    logic takePix;

    assign busKind = pmpu_bus_kind(st_reg.strap);
    assign r = pixRgb[17:12];
    assign g = pixRgb[11:6];
    assign b = pixRgb[5:0];
    assign takeCmd = st_reg.cmdReady && cmdValid;
    assign takePix = st_reg.pixReady && pixValid && !cmdValid;

    always_comb begin
        st_next = st_reg;
        // mode pins driven from the strap choice
        st_next.strap = strapSelect;
        st_next.strobeN = 1'b1;
        st_next.gap = 1'b0;
        if (st_reg.idx != st_reg.nWords && !st_reg.gap && !bus.busyWait) begin
            st_next.lines = pmpu_word_to_lines(st_reg.words[st_reg.idx], busKind);
            st_next.dcSelect = !st_reg.isCmd;
            st_next.strobeN = 1'b0;
            st_next.idx = 2'(st_reg.idx + 1'b1);
            st_next.gap = 1'b1;
        end
        if (takeCmd) begin
            st_next.words[0] = (busKind == BUS_NINE) ? {7'h00, cmdCode, 1'b0} : {8'h00, cmdCode};
            st_next.nWords = 2'd1;
            st_next.idx = 2'd0;
            st_next.isCmd = 1'b1;
            st_next.pairPhase = 1'b0;
        end else if (takePix) begin
            st_next.idx = 2'd0;
            st_next.isCmd = 1'b0;
            st_next.nWords = 2'd2;
            if (hostPixelFormat != `PMPU_FMT_565 && hostPixelFormat != `PMPU_FMT_666) begin
                st_next.nWords = 2'd0;
            end else if (busKind == BUS_NINE) begin
                if (hostPixelFormat == `PMPU_FMT_565) begin
                    st_next.words[0] = {8'h00, r[5:1], g[5:3]};
                    st_next.words[1] = {8'h00, g[2:0], b[5:1]};
                end else if (wideTransferMode == `PMPU_MDT_01) begin
                    st_next.words[0] = {8'h00, r, 2'h0};
                    st_next.words[1] = {8'h00, g, 2'h0};
                    st_next.words[2] = {8'h00, b, 2'h0};
                    st_next.nWords = 2'd3;
                end else begin
                    st_next.words[0] = {7'h00, r, g[5:3]};
                    st_next.words[1] = {7'h00, g[2:0], b};
                end
            end else if (hostPixelFormat == `PMPU_FMT_565) begin
                st_next.words[0] = {r[5:1], g, b[5:1]};
                st_next.nWords = 2'd1;
            end else begin
                unique case (wideTransferMode)
                    `PMPU_MDT_00: begin
                        if (!st_reg.pairPhase) begin
                            st_next.words[0] = {r, 2'h0, g, 2'h0};
                            st_next.nWords = 2'd1;
                            st_next.heldBlue = b;
                            st_next.pairPhase = 1'b1;
                        end else begin
                            st_next.words[0] = {st_reg.heldBlue, 2'h0, r, 2'h0};
                            st_next.words[1] = {g, 2'h0, b, 2'h0};
                            st_next.pairPhase = 1'b0;
                        end
                    end
                    `PMPU_MDT_01: begin
                        // blue alone in the second write
                        st_next.words[0] = {r, 2'h0, g, 2'h0};
                        st_next.words[1] = {b, 10'h000};
                    end
                    `PMPU_MDT_10: begin
                        st_next.words[0] = {r, g, b[5:2]};
                        st_next.words[1] = {b[1:0], 14'h0000};
                    end
                    `PMPU_MDT_11: begin
                        st_next.words[0] = {14'h0000, r[5:4]};
                        st_next.words[1] = {r[3:0], g, b};
                    end
                endcase
            end
        end
        // ready only once every queued word is out and nothing was taken now
        st_next.cmdReady = (st_next.idx == st_next.nWords) && !takeCmd && !takePix;
        st_next.pixReady = st_next.cmdReady;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '{strobeN: 1'b1, default: '0};
        end else if (clkEnable) begin
            st_reg <= st_next;
        end
    end

    assign bus.parallelDataLines = st_reg.lines;
    assign bus.dataCommandSelect = st_reg.dcSelect;
    assign bus.writeStrobeN = st_reg.strobeN;
    assign bus.interfaceModePins = st_reg.strap;
    assign cmdReady = st_reg.cmdReady;
    assign pixReady = st_reg.pixReady;
endmodule : pmpu_host

// file: pmpu_top_note_placeholder.sv
// intentionally empty compilation unit kept out of the build

// file: pmpu_props.sv
// checks on the parallel write bus joining the host end and the device end
// assumes one clock; rstn is the device end's reset
module pmpu_props (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [17:0] parallelDataLines,
    input wire logic dataCommandSelect,
    input wire logic writeStrobeN,
    input wire logic busyWait,
    input wire logic [3:0] interfaceModePins
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    logic wrNow, nine, wideOne, wideTwo;
    assign wrNow = !writeStrobeN;
    assign nine = interfaceModePins == 4'hB;
    assign wideOne = interfaceModePins == 4'h1;
    assign wideTwo = interfaceModePins == 4'h8;
    chk_single_strobe: assert property (wrNow |=> !wrNow)
        else $error("strobe low two cycles");
    chk_strap_known: assert property (wrNow |-> nine || wideOne || wideTwo)
        else $error("write on unknown strap");
    chk_strap_steady: assert property (wrNow |-> $stable(interfaceModePins))
        else $error("strap moved near a write");
    chk_nine_idle: assert property (wrNow && nine |-> parallelDataLines[8:0] == 9'h000)
        else $error("nine-bit write drives low lines");
    chk_wide_top_idle: assert property (
        wrNow && wideOne |-> parallelDataLines[17:16] == 2'h0)
        else $error("wide write drives top lines");
    chk_wide_gaps: assert property (
        wrNow && wideTwo |-> !parallelDataLines[9] && !parallelDataLines[0])
        else $error("skipped line driven");
    chk_cmd_low_byte: assert property (
        wrNow && !dataCommandSelect && wideOne |-> parallelDataLines[15:8] == 8'h00)
        else $error("command above low byte");
    chk_cmd_mid_byte: assert property (
        wrNow && !dataCommandSelect && wideTwo |-> parallelDataLines[17:10] == 8'h00)
        else $error("command outside lines 8 to 1");
endmodule : pmpu_props

// file: parallel_mcu_pixel_unpacker_tb.sv
// host end drives device end across the bus; items are checked at the device
// assumes the design files and pmpu_props.sv are compiled before this file
module parallel_mcu_pixel_unpacker_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, hostRstn = 1'b0, devRstn = 1'b0;
    logic [3:0] strapSelect = 4'h1;
    logic [2:0] hostPixelFormat = 3'h5;
    logic [1:0] wideTransferMode = 2'h0;
    logic cmdValid = 1'b0, pixValid = 1'b0, itemReady = 1'b1;
    logic [7:0] cmdCode = 8'h00;
    pmpu_pkg::pmpu_lines_t pixRgb = 18'h00000, itemData;
    logic cmdReady, pixReady, itemValid, itemIsCommand, itemIsWide, busKnown;
    logic [19:0] seen[$];
    int badCount = 0, checksDone = 0, strobes = 0, cycles = 0;
    pmpu_if bus ();
    always #50 core_clk = ~core_clk;
    pmpu_host u_pmpu_host (.core_clk(core_clk), .rstn(hostRstn), .clkEnable(1'b1), .bus(bus),
        .strapSelect(strapSelect), .hostPixelFormat(hostPixelFormat),
        .wideTransferMode(wideTransferMode), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdReady(cmdReady), .pixValid(pixValid), .pixRgb(pixRgb), .pixReady(pixReady));
    pmpu_device u_pmpu_device (.core_clk(core_clk), .rstn(devRstn), .clkEnable(1'b1), .bus(bus),
        .hostPixelFormat(hostPixelFormat), .wideTransferMode(wideTransferMode),
        .itemReady(itemReady), .itemValid(itemValid), .itemIsCommand(itemIsCommand),
        .itemIsWide(itemIsWide), .itemData(itemData), .busKnown(busKnown));
    pmpu_props u_pmpu_props (.core_clk(core_clk), .rstn(devRstn),
        .parallelDataLines(bus.parallelDataLines), .dataCommandSelect(bus.dataCommandSelect),
        .writeStrobeN(bus.writeStrobeN), .busyWait(bus.busyWait),
        .interfaceModePins(bus.interfaceModePins));
    // sampled mid-cycle so register updates at the rising edge have settled
    always @(negedge core_clk) begin
        if (!bus.writeStrobeN) strobes++;
        if (devRstn && itemValid && itemReady) seen.push_back({itemIsCommand, itemIsWide, itemData});
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            wrapUp();
        end
    end
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic send(input logic isCmd, input logic [17:0] val, output logic taken);
        int n;
        n = 0;
        @(posedge core_clk);
        cmdValid <= isCmd;
        pixValid <= !isCmd;
        cmdCode <= val[7:0];
        pixRgb <= val;
        do begin
            @(negedge core_clk);
            n++;
        end while (!(isCmd ? cmdReady : pixReady) && n < 60);
        taken = isCmd ? cmdReady : pixReady;
        @(posedge core_clk);
        cmdValid <= 1'b0;
        pixValid <= 1'b0;
    endtask : send
    task automatic drain(input logic [19:0] exp[$]);
        for (int i = 0; i < 400 && seen.size() < exp.size(); i++) @(negedge core_clk);
        @(posedge core_clk);
        cmp(20'(seen.size()), 20'(exp.size()));
        foreach (exp[i]) cmp(seen.size() > 0 ? seen.pop_front() : 20'hXXXXX, exp[i]);
    endtask : drain
    task automatic wrapUp();
        $display("comparisons %0d, mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrapUp
    initial begin
        logic ok;
        logic [2:0] fmt;
        logic [19:0] exp[$];
        logic [17:0] pix[2] = '{18'h2A5C3, 18'h15A3C};
        logic [3:0] straps[3] = '{4'hB, 4'h1, 4'h8};
        logic [4:0] modes[6] = '{5'h14, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C};
        int w;
        foreach (straps[s]) begin
            hostRstn <= 1'b0;
            devRstn <= 1'b0;
            strapSelect <= straps[s];
            repeat (6) @(posedge core_clk);
            // device samples the strap, so the host end must be out of reset first
            hostRstn <= 1'b1;
            repeat (2) @(posedge core_clk);
            devRstn <= 1'b1;
            repeat (2) @(posedge core_clk);
            cmp(20'(busKnown), 20'h00001);
            foreach (modes[m]) begin
                fmt = modes[m][4:2];
                hostPixelFormat <= fmt;
                wideTransferMode <= modes[m][1:0];
                strobes = 0;
                // command items carry their flag in the top bit of the 20-bit item
                exp = '{{12'h800, 8'(8'hA0 + m)}};
                send(1'b1, {10'h000, 8'(8'hA0 + m)}, ok);
                foreach (pix[p]) send(1'b0, pix[p], ok);
                if (fmt != 3'h7) begin
                    foreach (pix[p]) exp.push_back({1'b0, fmt == 3'h6,
                        fmt == 3'h5 ? pix[p] & 18'h3EFFE : pix[p]});
                end
                w = (fmt == 3'h7) ? 0 : (straps[s] == 4'hB) ? ((modes[m] == 5'h19) ? 6 : 4)
                    : (fmt == 3'h5) ? 2 : (modes[m] == 5'h18) ? 3 : 4;
                drain(exp);
                cmp(20'(strobes), 20'(w + 1));
            end
        end
        itemReady <= 1'b0;
        exp.delete();
        for (int i = 0; i < 8; i++) begin
            send(1'b1, 18'(8'h30 + i), ok);
            if (ok) exp.push_back({12'h800, 8'(8'h30 + i)});
            if (!ok) break;
        end
        cmp({19'h00000, bus.busyWait}, 20'h00001);
        cmp(20'(exp.size() < 8), 20'h00001);
        itemReady <= 1'b1;
        drain(exp);
        wrapUp();
    end
endmodule : parallel_mcu_pixel_unpacker_tb
